/* File: hw/tmp_ctrl.sv */
// Purpose: 10 Mb/s test pattern control, self-test tally, heartbeat and jabber gating
// Assumes: line-side strobes synchronous to pclk
// Notes:   registers at 4x index; only tone runs without gaps
`timescale 1ns/1ps
`default_nettype none
module tmp_ctrl #(
    parameter int GAP_LONG  = tmp_pkg::GAP_LONG_CYC,
    parameter int GAP_SHORT = tmp_pkg::GAP_SHORT_CYC,
    parameter int BURST     = tmp_pkg::BURST_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        speed_10,
    input  wire logic        full_duplex,
    input  wire logic        selftest_start,
    input  wire logic        selftest_run,
    input  wire logic        rx_nibble_bad,
    output logic             sqe_enable,
    output logic             tx_guard_enable,
    output logic             pat_active,
    output logic      [1:0]  pat_kind,
    output logic             prbs_nonstop,
    output logic             irq
);
    // ----------------------------------------
    // registers and bus decode
    // ----------------------------------------
    logic [15:0] sc_reg;
    logic [15:0] ext_reg;
    logic [7:0]  tally;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    tmp_pkg::tmp_state_t state;
    logic [15:0] cnt;

    wire acc      = psel && penable && ce;
    wire wr       = acc && pwrite;
    wire hit_sc   = (paddr == tmp_pkg::ADDR_TBT_SC);
    wire hit_ext  = (paddr == tmp_pkg::ADDR_LT_EXT);
    wire hit_st   = (paddr == tmp_pkg::ADDR_IRQ_STAT);
    wire hit_msk  = (paddr == tmp_pkg::ADDR_IRQ_MASK);
    wire mapped   = hit_sc || hit_ext || hit_st || hit_msk;
    wire sqe_off     = sc_reg[tmp_pkg::SC_SQE_OFF_BIT];
    wire guard_off   = sc_reg[tmp_pkg::SC_TX_GUARD_OFF_BIT];
    wire pat_on      = ext_reg[tmp_pkg::EXT_PAT_ON_BIT];
    wire gap_long    = ext_reg[tmp_pkg::EXT_GAP_BIT];
    wire nonstop     = ext_reg[tmp_pkg::EXT_NONSTOP_BIT];
    wire [1:0] choice = ext_reg[tmp_pkg::EXT_CHOICE_LSB +: 2];
    // writable bits only: reserved 7:6 and 3 kept zero
    wire [15:0] ext_wmask = 16'h0037;
    wire [15:0] sc_wmask  = 16'h0003;
    wire [15:0] ext_view  = {tally, ext_reg[7:0]};
    wire [15:0] rd_mux    = hit_sc  ? sc_reg :
                            hit_ext ? ext_view :
                            hit_st  ? {14'h0, irq_stat} :
                            hit_msk ? {14'h0, irq_mask} : 16'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= {16'h0000, rd_mux};
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // reset clears fields except reserved bit 2 of sc_reg, which reset sets to one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc_reg   <= tmp_pkg::SC_RESET;
            ext_reg  <= tmp_pkg::EXT_RESET;
            irq_mask <= 2'h0;
        end else if (wr && pready) begin
            if (hit_sc)
                sc_reg <= (pwdata[15:0] & sc_wmask) | tmp_pkg::SC_RESET;
            if (hit_ext)
                ext_reg <= pwdata[15:0] & ext_wmask;
            if (hit_msk)
                irq_mask <= pwdata[1:0];
        end
    end

    // ----------------------------------------
    // self-test bad nibble tally
    // ----------------------------------------
    wire tally_max = (tally == 8'hFF);
    wire [7:0] next_tally = selftest_start ? 8'h00 :
                            (selftest_run && rx_nibble_bad && !tally_max) ? tally + 8'h01 : tally;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tally <= 8'h00;
        else if (ce)
            tally <= next_tally;
    end

    // ----------------------------------------
    // pattern sequencer
    // ----------------------------------------
    // only the tone stream has no gap between sequences; nonstop does not change the gaps
    wire gapless = (choice == tmp_pkg::PAT_TONE);
    wire [15:0] gap_len = gap_long ? 16'(GAP_LONG) : 16'(GAP_SHORT);
    // only a sequence that really goes on into a gap raises the event
    wire seq_done = (state == tmp_pkg::TMP_BURST) && (cnt == 16'(BURST - 1)) && !gapless
                    && pat_on && speed_10;

    // pattern gated by enable, gap length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= tmp_pkg::TMP_IDLE;
            cnt   <= 16'h0000;
        end else if (ce) begin
            case (state)
                tmp_pkg::TMP_IDLE: begin
                    cnt <= 16'h0000;
                    if (pat_on && speed_10)
                        state <= tmp_pkg::TMP_BURST;
                end
                tmp_pkg::TMP_BURST: begin
                    if (!pat_on || !speed_10) begin
                        state <= tmp_pkg::TMP_IDLE;
                    end else if (seq_done) begin
                        state <= tmp_pkg::TMP_GAP;
                        cnt   <= 16'h0000;
                    end else if (!gapless) begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                tmp_pkg::TMP_GAP: begin
                    if (!pat_on || !speed_10) begin
                        state <= tmp_pkg::TMP_IDLE;
                    end else if (cnt >= gap_len - 16'h0001) begin
                        state <= tmp_pkg::TMP_BURST;
                        cnt   <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                default: state <= tmp_pkg::TMP_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // line-side controls
    // ----------------------------------------
    wire half10 = speed_10 && !full_duplex;
    // honour sqe off at 10M half, else off
    wire next_sqe   = half10 && !sqe_off;
    // guard off only in 10BASE-T; software sets it before nonstop
    wire next_guard = !(speed_10 && guard_off);
    wire next_nonstop = nonstop && selftest_run;
    wire next_active = pat_on && speed_10 && (state == tmp_pkg::TMP_BURST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sqe_enable      <= 1'b0;
            tx_guard_enable <= 1'b1;
            pat_active      <= 1'b0;
            pat_kind        <= tmp_pkg::PAT_DATA_A;
            prbs_nonstop    <= 1'b0;
        end else if (ce) begin
            sqe_enable      <= next_sqe;
            tx_guard_enable <= next_guard;
            pat_active      <= next_active;
            pat_kind        <= choice;
            prbs_nonstop    <= next_nonstop;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    wire sat_evt = selftest_run && rx_nibble_bad && (tally == 8'hFE) && !selftest_start;
    wire [1:0] evt = {seq_done, sat_evt};
    wire [1:0] w1c = (wr && pready && hit_st) ? pwdata[1:0] : 2'h0;
    // set wins over clear
    wire [1:0] next_stat = (irq_stat & ~w1c) | evt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 2'h0;
            irq      <= 1'b0;
        end else if (ce) begin
            irq_stat <= next_stat;
            irq      <= |(next_stat & irq_mask);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // tally holds at max
    a_tally_sat_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && tally_max && !selftest_start) |=> tally == 8'hFF)
        else $error("tally left max");
    a_tally_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && selftest_start) |=> tally == 8'h00)
        else $error("tally not cleared");
    a_tally_count: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && selftest_run && rx_nibble_bad && !selftest_start && !tally_max)
        |=> tally == $past(tally) + 8'h01)
        else $error("tally not counted");
    // heartbeat off at 100M or full duplex
    a_sqe_fast_off: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && (!speed_10 || full_duplex)) |=> !sqe_enable)
        else $error("heartbeat on outside 10M half");
    // sqe follows bit at 10M half
    a_sqe_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && half10) |=> sqe_enable == !$past(sqe_off))
        else $error("heartbeat ignores bit");
    a_guard_fast_on: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !speed_10) |=> tx_guard_enable)
        else $error("jabber guard off at 100M");
    a_pat_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !pat_on) |=> !pat_active)
        else $error("pattern while disabled");
    // gap length by select bit
    // own count of gap cycles, so an early exit of the sequencer shows
    logic [15:0] gap_seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            gap_seen <= 16'h0000;
        else if (ce)
            gap_seen <= (state == tmp_pkg::TMP_GAP) ? gap_seen + 16'h0001 : 16'h0000;
    end
    sequence s_gap_exit;
        (ce && state == tmp_pkg::TMP_GAP) ##1 (state == tmp_pkg::TMP_BURST);
    endsequence
    a_gap_len: assert property (@(posedge pclk) disable iff (!presetn)
        s_gap_exit |-> gap_seen >= $past(gap_len))
        else $error("gap ended early");
    a_kind_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> pat_kind == $past(choice))
        else $error("pattern kind wrong");
    a_nonstop: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && nonstop && selftest_run) |=> prbs_nonstop)
        else $error("nonstop stream missing");
endmodule : tmp_ctrl
`default_nettype wire

/* File: hw/tmp_pkg.sv */
// Purpose: constants for the 10 Mb/s test pattern and self-test control block
// Assumes: APB byte addresses are four times the register index
// Notes:   shared by the design and its bench
package tmp_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0]  IDX_TBT_SC     = 8'h1A;
    localparam logic [7:0]  IDX_LT_EXT     = 8'h1B;
    localparam logic [7:0]  IDX_IRQ_STAT   = 8'h1E;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h1F;
    localparam logic [11:0] ADDR_TBT_SC    = {2'h0, IDX_TBT_SC, 2'h0};
    localparam logic [11:0] ADDR_LT_EXT    = {2'h0, IDX_LT_EXT, 2'h0};
    localparam logic [11:0] ADDR_IRQ_STAT  = {2'h0, IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] ADDR_IRQ_MASK  = {2'h0, IDX_IRQ_MASK, 2'h0};
    // ----------------------------------------
    // fields
    // ----------------------------------------
    localparam int SC_TX_GUARD_OFF_BIT = 0;
    localparam int SC_SQE_OFF_BIT      = 1;
    localparam int SC_RSVD_ONE_BIT     = 2;
    localparam int EXT_CHOICE_LSB      = 0;
    localparam int EXT_GAP_BIT         = 2;
    localparam int EXT_PAT_ON_BIT      = 4;
    localparam int EXT_NONSTOP_BIT     = 5;
    localparam int EXT_TALLY_LSB       = 8;
    localparam int IRQ_SAT_BIT         = 0;
    localparam int IRQ_SEQ_BIT         = 1;
    localparam logic [15:0] SC_RESET   = 16'h0004;
    localparam logic [15:0] EXT_RESET  = 16'h0000;
    // ----------------------------------------
    // timing at 250 MHz
    // ----------------------------------------
    localparam int CLK_MHZ       = 250;
    localparam int GAP_SHORT_US  = 10;
    localparam int GAP_LONG_US   = 15;
    localparam int GAP_SHORT_CYC = GAP_SHORT_US * CLK_MHZ;
    localparam int GAP_LONG_CYC  = GAP_LONG_US * CLK_MHZ;
    localparam int BURST_CYC     = 64;
    localparam logic [1:0] PAT_DATA_A = 2'h0;
    localparam logic [1:0] PAT_DATA_B = 2'h1;
    localparam logic [1:0] PAT_LINK   = 2'h2;
    localparam logic [1:0] PAT_TONE   = 2'h3;
    typedef enum logic [1:0] {
        TMP_IDLE  = 2'h0,
        TMP_BURST = 2'h1,
        TMP_GAP   = 2'h3
    } tmp_state_t;
endpackage : tmp_pkg

/* File: test/ten_meg_test_pattern_control_tb.sv */
// Purpose: register and line checks of the test pattern control block
// Assumes: short gap parameters 30/20/8, ce held high
// Notes:   pready and read data taken at the rising edge that ends the access
`timescale 1ns/1ps
`default_nettype none
module ten_meg_test_pattern_control_tb;
    localparam int GL = 30;
    localparam int GS = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, sqe, guard, pat_active, nonstop, irq, bad, busy;
    logic speed_10 = 1'b0, full_duplex = 1'b0, st_start = 1'b0, st_run = 1'b0, go = 1'b0;
    logic [1:0] pat_kind;
    logic [9:0] cnt = 10'h000;
    int err_count = 0, samples_checked = 0, n;
    always #2 pclk = ~pclk;
    tmp_ctrl #(.GAP_LONG(GL), .GAP_SHORT(GS), .BURST(8)) i_tmp_ctrl (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .speed_10(speed_10),
        .full_duplex(full_duplex), .selftest_start(st_start), .selftest_run(st_run),
        .rx_nibble_bad(bad), .sqe_enable(sqe), .tx_guard_enable(guard),
        .pat_active(pat_active), .pat_kind(pat_kind), .prbs_nonstop(nonstop), .irq(irq));
    tmp_line_model i_tmp_line_model (.pclk(pclk), .presetn(presetn), .go(go),
        .count(cnt), .rx_nibble_bad(bad), .busy(busy));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 50) begin
            t++;
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (t >= 50) chk("pready", 32'h1, 32'h0);
    endtask : apb
    task automatic settle();
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk
    task automatic restart();
        @(posedge pclk); st_start <= 1'b1; st_run <= 1'b1;
        @(posedge pclk); st_start <= 1'b0;
        settle();
    endtask : restart
    task automatic send(input logic [9:0] k);
        int t = 0;
        @(posedge pclk); go <= 1'b1; cnt <= k;
        @(posedge pclk); go <= 1'b0;
        @(negedge pclk);
        while (busy !== 1'b0 && t < 1000) begin t++; @(negedge pclk); end
        settle();
    endtask : send
    // low time between two bursts, counted at negedges
    task automatic gap_len(output int g);
        int t = 0;
        g = 0;
        @(negedge pclk);
        while (pat_active !== 1'b1 && t < 500) begin t++; @(negedge pclk); end
        while (pat_active === 1'b1 && t < 500) begin t++; @(negedge pclk); end
        while (pat_active !== 1'b1 && t < 500) begin g++; t++; @(negedge pclk); end
    endtask : gap_len
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(tmp_pkg::ADDR_TBT_SC, {16'h0, tmp_pkg::SC_RESET}, "sc_rst");
        rchk(tmp_pkg::ADDR_LT_EXT, 32'h0, "ext_rst");
        chk("guard_rst", 32'h1, {31'h0, guard});
        apb(1'b0, 12'hFF0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        chk("unmapped_rd", 32'h0, rd);
        @(posedge pclk); speed_10 <= 1'b1;
        apb(1'b1, tmp_pkg::ADDR_TBT_SC, 32'h2);
        settle();
        chk("sqe_off", 32'h0, {31'h0, sqe});
        rchk(tmp_pkg::ADDR_TBT_SC, 32'h6, "sc_rw");
        apb(1'b1, tmp_pkg::ADDR_TBT_SC, 32'h0);
        settle();
        chk("sqe_on", 32'h1, {31'h0, sqe});
        chk("guard_on", 32'h1, {31'h0, guard});
        @(posedge pclk); full_duplex <= 1'b1;
        settle();
        chk("sqe_fd", 32'h0, {31'h0, sqe});
        @(posedge pclk); full_duplex <= 1'b0; speed_10 <= 1'b0;
        settle();
        chk("sqe_100", 32'h0, {31'h0, sqe});
        @(posedge pclk); speed_10 <= 1'b1;
        apb(1'b1, tmp_pkg::ADDR_TBT_SC, 32'h1);
        settle();
        chk("guard_off", 32'h0, {31'h0, guard});
        @(posedge pclk);
        speed_10 <= 1'b0;
        settle();
        chk("guard_100", 32'h1, {31'h0, guard});
        @(posedge pclk);
        speed_10 <= 1'b1;
        settle();
        restart();
        send(10'd5);
        rchk(tmp_pkg::ADDR_LT_EXT, 32'h0500, "tally5");
        apb(1'b1, tmp_pkg::ADDR_LT_EXT, 32'hFF00);
        rchk(tmp_pkg::ADDR_LT_EXT, 32'h0500, "tally_ro");
        send(10'd300);
        rchk(tmp_pkg::ADDR_LT_EXT, 32'hFF00, "tally_sat");
        rchk(tmp_pkg::ADDR_IRQ_STAT, 32'h1, "irq_sat");
        apb(1'b1, tmp_pkg::ADDR_IRQ_MASK, 32'h0);
        settle();
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, tmp_pkg::ADDR_IRQ_MASK, 32'h1);
        settle();
        chk("irq_mask", 32'h1, {31'h0, irq});
        apb(1'b1, tmp_pkg::ADDR_IRQ_STAT, 32'h1);
        settle();
        rchk(tmp_pkg::ADDR_IRQ_STAT, 32'h0, "irq_w1c");
        chk("irq_low", 32'h0, {31'h0, irq});
        restart();
        rchk(tmp_pkg::ADDR_LT_EXT, 32'h0, "tally_clr");
        apb(1'b1, tmp_pkg::ADDR_LT_EXT, 32'h20);
        settle();
        chk("nonstop", 32'h1, {31'h0, nonstop});
        @(posedge pclk); st_run <= 1'b0;
        settle();
        chk("nonstop_off", 32'h0, {31'h0, nonstop});
        apb(1'b1, tmp_pkg::ADDR_LT_EXT, 32'h0);
        n = 0;
        repeat (60) begin @(negedge pclk); n += (pat_active !== 1'b0); end
        chk("pat_off", 32'h0, n);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, tmp_pkg::ADDR_LT_EXT, 32'h10 | k);
            settle();
            chk("pat_kind", k, {30'h0, pat_kind});
            n = 0;
            while (pat_active !== 1'b1 && n < 50) begin n++; @(negedge pclk); end
            chk("pat_on", 32'h1, {31'h0, pat_active});
        end
        apb(1'b1, tmp_pkg::ADDR_LT_EXT, 32'h10);
        gap_len(n);
        chk("gap_short", GS, n);
        apb(1'b1, tmp_pkg::ADDR_LT_EXT, 32'h14);
        gap_len(n);
        chk("gap_long", GL, n);
        rchk(tmp_pkg::ADDR_IRQ_STAT, 32'h2, "irq_seq");
        restart();
        send(10'd3);
        rchk(tmp_pkg::ADDR_LT_EXT, 32'h0314, "tally3");
        // reset in mid-run, with tally and fields nonzero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(tmp_pkg::ADDR_LT_EXT, 32'h0, "ext_rst2");
        rchk(tmp_pkg::ADDR_TBT_SC, {16'h0, tmp_pkg::SC_RESET}, "sc_rst2");
        tally_and_finish();
    end
endmodule : ten_meg_test_pattern_control_tb
`default_nettype wire

/* File: test/tmp_line_model.sv */
// Purpose: line-side source of errored nibbles for the self-test tally
// Assumes: one pulse per bad nibble, in the pclk domain
// Notes:   pulses two cycles apart, real nibbles never arrive back to back
`timescale 1ns/1ps
`default_nettype none
module tmp_line_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic [9:0] count,
    output logic            rx_nibble_bad,
    output logic            busy
);
    logic [10:0] left;
    assign busy = (left != 11'h000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left          <= 11'h000;
            rx_nibble_bad <= 1'b0;
        end else if (go) begin
            left          <= {count, 1'b0};
            rx_nibble_bad <= 1'b0;
        end else begin
            left          <= busy ? left - 11'h001 : left;
            rx_nibble_bad <= busy & left[0];
        end
    end
endmodule : tmp_line_model
`default_nettype wire
